/* File: include/mcr_pkg.sv */
// shared constants and types for the motion command register block
package mcr_pkg;
    // register addresses in the device's modbus map
    localparam logic [15:0] ADDR_TGT_HI = 16'h9900;
    localparam logic [15:0] ADDR_TGT_LO = 16'h9901;
    localparam logic [15:0] ADDR_BAND_HI = 16'h9902;
    localparam logic [15:0] ADDR_BAND_LO = 16'h9903;
    localparam logic [15:0] ADDR_SPD_HI = 16'h9904;
    localparam logic [15:0] ADDR_SPD_LO = 16'h9905;
    localparam logic [15:0] ADDR_ACCEL = 16'h9906;
    localparam logic [15:0] ADDR_PRESS = 16'h9907;
    localparam logic [15:0] ADDR_FLAGS = 16'h9908;
    // accel limits, hundredths of g
    localparam logic [15:0] ACCEL_MIN = 16'h0001;
    localparam logic [15:0] ACCEL_TOP = 16'h012C;
    // press current limits, full rated current is 255
    localparam logic [15:0] PRESS_FULL = 16'h00FF;
    localparam logic [15:0] PRESS_MIN = 16'h0033;
    localparam logic [15:0] PRESS_STD_MAX = 16'h00B2;
    localparam logic [15:0] PRESS_HI_MAX = 16'h01FE;
    // control flag field positions
    localparam int FLG_PUSH = 1;
    localparam int FLG_DIR = 2;
    localparam int FLG_INC = 3;
    localparam int FLG_GAIN = 4;
    localparam int FLG_RAMP = 6;
    localparam int FLG_VIB = 12;
    localparam logic [15:0] FLG_MASK = 16'h30FE;
    localparam logic [15:0] FLG_RESET = 16'h0000;
    // user parameter defaults (speed, accel, band in 0.01 units)
    localparam logic [31:0] PRM_DEF_SPEED = 32'h0000_2710;
    localparam logic [15:0] PRM_DEF_ACCEL = 16'h001E;
    localparam logic [31:0] PRM_DEF_BAND = 32'h0000_000A;
    localparam logic [15:0] PRM_MAX_ACCEL = 16'h012C;
    // host command and status register offsets
    localparam logic [3:0] HREG_ADDR = 4'h0;
    localparam logic [3:0] HREG_DATA = 4'h1;
    localparam logic [3:0] HREG_GO = 4'h2;
    localparam logic [3:0] HREG_STAT = 4'h3;
    localparam logic [3:0] HREG_RDATA = 4'h4;
    // ramp profile codes
    typedef enum logic [1:0] {
        MCR_RAMP_TRAP = 2'h0,
        MCR_RAMP_SCURVE = 2'h1,
        MCR_RAMP_FILTER = 2'h2,
        MCR_RAMP_BAD = 2'h3
    } mcr_ramp_t;
endpackage

/* File: include/mcr_if.sv */
// register link between host controller and device
`timescale 1ns/10ps
interface mcr_if;
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
    logic [15:0] addr; // register address
    logic [15:0] wdata; // write data
    logic [15:0] rdata; // read data, cycle after rd
    logic ack; // write accepted pulse, echoes address
    logic [15:0] ack_addr; // echoed start address
    modport dev (input wr, input rd, input addr, input wdata,
                 output rdata, output ack, output ack_addr);
    modport host (output wr, output rd, output addr, output wdata,
                  input rdata, input ack, input ack_addr);
endinterface

/* File: core/mcr_rel_acc.sv */
// relative move accumulator working in 0.01 mm units
`timescale 1ns/10ps
module mcr_rel_acc (
    input wire logic clk,
    input wire logic nrst,
    input wire logic load, // one-cycle: take new base
    input wire logic [31:0] base, // base position, 0.01 mm
    input wire logic [31:0] delta, // relative step, 0.01 mm
    output logic [31:0] sum // base plus step, registered
);
    // summing in mm units before pulse conversion keeps no fraction error
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sum <= 32'h0000_0000;
        end else if (load) begin
            sum <= base + delta; // [RULE_11]
        end
    end
endmodule

/* File: core/mcr_device.sv */
// device end: motion command registers and move launch
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
// Contract
// RULE_01 - accel in 0.01 g, range 1 to 012C
// RULE_02 - accel above maximum alarms at start
// RULE_03 - accel write starts motion, applies live
// RULE_04 - host keeps press limit 33..B2 or 1FE
// RULE_05 - press limit 255 is full current
// RULE_06 - press write starts motion, live in push
// RULE_07 - flags return to default each move
// RULE_08 - bit 1 selects push mode
// RULE_09 - bit 2 push direction, push only
// RULE_10 - bit 3 incremental, base depends on mode
// RULE_11 - relative sums in mm before pulses
// RULE_12 - bits 4-5 gain set select
// RULE_13 - bits 6-7 ramp profile, 11 unusable
// RULE_14 - host sets profile before move command
// RULE_15 - bits 12-13 vibration set select
// RULE_16 - target-only move uses user parameters
// RULE_17 - multi write answered with echo
// RULE_18 - host writes target hi then lo
// RULE_19 - target low word write starts motion
// RULE_20 - unassigned flag bits read zero
module mcr_device (
    input wire logic CLK_SYS,
    input wire logic NRST,
    mcr_if.dev LINK,
    input wire logic [31:0] CUR_POS, // present position, 0.01 mm
    input wire logic HIGH_THRUST, // variant with wider press range
    output logic MOVE_START, // one-cycle launch pulse
    output logic [31:0] MOVE_TARGET, // final target, 0.01 mm
    output logic [31:0] MOVE_SPEED, // speed, 0.01 mm/s
    output logic [15:0] MOVE_ACCEL, // accel, 0.01 g
    output logic [15:0] MOVE_PRESS, // press current limit
    output logic MOVE_PUSH, // push-motion move
    output logic MOVE_REVERSE, // push toward reverse
    output logic [1:0] MOVE_GAIN, // servo gain set
    output logic [1:0] MOVE_RAMP, // ramp profile
    output logic [1:0] MOVE_VIB, // vibration set, 0 off
    output logic ALARM // accel alarm, sticky until next good start
);
    logic [31:0] tgt_ff; // target register
    logic [15:0] tgt_hi_ff; // staged upper word
    logic [31:0] band_ff; // positioning band
    logic [31:0] spd_ff; // speed
    logic [15:0] accel_ff; // acceleration
    logic [15:0] press_ff; // press current limit
    logic [15:0] flags_ff; // control flags
    logic [15:0] rdata_ff; // read data
    logic ack_ff; // echo pulse
    logic [15:0] ack_addr_ff; // echoed address
    logic burst_ff; // inside a multi-word write
    logic start; // launch this cycle
    logic push_now; // push selected for this launch
    logic [31:0] inc_sum; // relative target result
    logic inc_load; // take relative base
    logic [31:0] inc_base;
    logic [31:0] nxt_target;
    logic [15:0] press_in; // written press limit after the variant clamp

    // launch decode: target low, accel, press writes start motion
    always_comb begin
        start = 1'b0;
        if (LINK.wr && LINK.addr == mcr_pkg::ADDR_TGT_LO) begin
            start = 1'b1; // [RULE_19]
        end else if (LINK.wr && LINK.addr == mcr_pkg::ADDR_ACCEL) begin
            start = 1'b1; // [RULE_03]
        end else if (LINK.wr && LINK.addr == mcr_pkg::ADDR_PRESS) begin
            start = 1'b1; // [RULE_06]
        end
    end

    assign push_now = flags_ff[mcr_pkg::FLG_PUSH]; // [RULE_08]
    // same clamp for the stored limit and the live one, so both agree
    assign press_in = (LINK.wdata > (HIGH_THRUST ? mcr_pkg::PRESS_HI_MAX
                                                 : mcr_pkg::PRESS_STD_MAX))
                      ? (HIGH_THRUST ? mcr_pkg::PRESS_HI_MAX : mcr_pkg::PRESS_STD_MAX)
                      : LINK.wdata; // [RULE_04]
    // incremental base: target in normal mode, present position in push
    assign inc_base = push_now ? CUR_POS : tgt_ff; // [RULE_10]
    assign inc_load = start && flags_ff[mcr_pkg::FLG_INC];

    mcr_rel_acc u_rel (
        .clk(CLK_SYS),
        .nrst(NRST),
        .load(inc_load),
        .base(inc_base),
        .delta((LINK.addr == mcr_pkg::ADDR_TGT_LO) ? {tgt_hi_ff, LINK.wdata} : 32'h0000_0000),
        .sum(inc_sum)
    );

    // target word assembly; hi staged, lo completes the value
    always_comb begin
        nxt_target = tgt_ff;
        if (LINK.wr && LINK.addr == mcr_pkg::ADDR_TGT_LO) begin
            nxt_target = {tgt_hi_ff, LINK.wdata}; // [RULE_18]
        end
    end

    // motion register writes
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            tgt_ff <= 32'h0000_0000;
            tgt_hi_ff <= 16'h0000;
            band_ff <= mcr_pkg::PRM_DEF_BAND;
            spd_ff <= mcr_pkg::PRM_DEF_SPEED;
            accel_ff <= mcr_pkg::PRM_DEF_ACCEL;
            press_ff <= mcr_pkg::PRESS_FULL;
        end else if (LINK.wr) begin
            tgt_ff <= nxt_target;
            if (LINK.addr == mcr_pkg::ADDR_TGT_HI) begin
                tgt_hi_ff <= LINK.wdata;
            end else if (LINK.addr == mcr_pkg::ADDR_BAND_HI) begin
                band_ff[31:16] <= LINK.wdata;
            end else if (LINK.addr == mcr_pkg::ADDR_BAND_LO) begin
                band_ff[15:0] <= LINK.wdata;
            end else if (LINK.addr == mcr_pkg::ADDR_SPD_HI) begin
                spd_ff[31:16] <= LINK.wdata;
            end else if (LINK.addr == mcr_pkg::ADDR_SPD_LO) begin
                spd_ff[15:0] <= LINK.wdata;
            end else if (LINK.addr == mcr_pkg::ADDR_ACCEL) begin
                accel_ff <= LINK.wdata; // [RULE_01]
            end else if (LINK.addr == mcr_pkg::ADDR_PRESS) begin
                // clamp to the maximum the variant allows; 255 is full current
                if (LINK.wdata > (HIGH_THRUST ? mcr_pkg::PRESS_HI_MAX
                                              : mcr_pkg::PRESS_STD_MAX)) begin
                    press_ff <= HIGH_THRUST ? mcr_pkg::PRESS_HI_MAX
                                            : mcr_pkg::PRESS_STD_MAX; // [RULE_04]
                end else begin
                    press_ff <= LINK.wdata; // [RULE_05]
                end
            end
        end
    end

    // control flags: write masks unused bits, any launch restores default
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            flags_ff <= mcr_pkg::FLG_RESET;
        end else if (start) begin
            flags_ff <= mcr_pkg::FLG_RESET; // [RULE_07]
        end else if (LINK.wr && LINK.addr == mcr_pkg::ADDR_FLAGS) begin
            flags_ff <= LINK.wdata & mcr_pkg::FLG_MASK; // [RULE_20]
        end
    end

    // launch outputs: move parameters latched with the start pulse
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            MOVE_START <= 1'b0;
            MOVE_TARGET <= 32'h0000_0000;
            MOVE_SPEED <= mcr_pkg::PRM_DEF_SPEED;
            MOVE_ACCEL <= mcr_pkg::PRM_DEF_ACCEL;
            MOVE_PRESS <= mcr_pkg::PRESS_FULL;
            MOVE_PUSH <= 1'b0;
            MOVE_REVERSE <= 1'b0;
            MOVE_GAIN <= 2'h0;
            MOVE_RAMP <= 2'h0;
            MOVE_VIB <= 2'h0;
        end else begin
            MOVE_START <= start;
            if (start) begin
                // untouched registers keep user parameter defaults
                MOVE_TARGET <= flags_ff[mcr_pkg::FLG_INC] ? inc_base + nxt_target
                                                          : nxt_target; // [RULE_16]
                MOVE_SPEED <= spd_ff;
                MOVE_ACCEL <= (LINK.addr == mcr_pkg::ADDR_ACCEL) ? LINK.wdata
                                                                  : accel_ff; // [RULE_03]
                MOVE_PRESS <= (LINK.addr == mcr_pkg::ADDR_PRESS) ? press_in
                                                                  : press_ff; // [RULE_06]
                MOVE_PUSH <= push_now; // [RULE_08]
                MOVE_REVERSE <= push_now & flags_ff[mcr_pkg::FLG_DIR]; // [RULE_09]
                MOVE_GAIN <= flags_ff[mcr_pkg::FLG_GAIN +: 2]; // [RULE_12]
                // unusable profile code falls back to trapezoid
                MOVE_RAMP <= (flags_ff[mcr_pkg::FLG_RAMP +: 2] == 2'h3) ? 2'h0
                             : flags_ff[mcr_pkg::FLG_RAMP +: 2]; // [RULE_13]
                MOVE_VIB <= flags_ff[mcr_pkg::FLG_VIB +: 2]; // [RULE_15]
            end
        end
    end

    // alarm at the launch moment when accel exceeds the maximum parameter or is below the minimum
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ALARM <= 1'b0;
        end else if (start) begin
            ALARM <= (((LINK.addr == mcr_pkg::ADDR_ACCEL) ? LINK.wdata : accel_ff)
                      > mcr_pkg::PRM_MAX_ACCEL)
                     || (((LINK.addr == mcr_pkg::ADDR_ACCEL) ? LINK.wdata : accel_ff)
                      < mcr_pkg::ACCEL_MIN); // [RULE_02]
        end
    end

    // read mux, data one cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rdata_ff <= 16'h0000;
        end else if (LINK.rd) begin
            if (LINK.addr == mcr_pkg::ADDR_TGT_HI) begin
                rdata_ff <= tgt_ff[31:16];
            end else if (LINK.addr == mcr_pkg::ADDR_TGT_LO) begin
                rdata_ff <= tgt_ff[15:0];
            end else if (LINK.addr == mcr_pkg::ADDR_ACCEL) begin
                rdata_ff <= accel_ff;
            end else if (LINK.addr == mcr_pkg::ADDR_PRESS) begin
                rdata_ff <= press_ff;
            end else if (LINK.addr == mcr_pkg::ADDR_FLAGS) begin
                rdata_ff <= flags_ff; // [RULE_20]
            end else begin
                rdata_ff <= 16'h0000; // unmapped, band and speed addresses read zero
            end
        end
    end

    // echo: first write of a burst gives the start address back
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ack_ff <= 1'b0;
            ack_addr_ff <= 16'h0000;
            burst_ff <= 1'b0;
        end else begin
            ack_ff <= LINK.wr; // [RULE_17]
            burst_ff <= LINK.wr;
            if (LINK.wr && !burst_ff) begin
                ack_addr_ff <= LINK.addr; // [RULE_17]
            end
        end
    end

    assign LINK.rdata = rdata_ff;
    assign LINK.ack = ack_ff & ~LINK.wr; // pulse after the last word
    assign LINK.ack_addr = ack_addr_ff;
endmodule

/* File: core/mcr_host.sv */
// host end: software port turned into device register writes and reads
`timescale 1ns/10ps
module mcr_host (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic [3:0] SW_ADDR, // command register index
    input wire logic [15:0] SW_WDATA,
    input wire logic SW_WR,
    input wire logic SW_RD,
    output logic [15:0] SW_RDATA, // valid cycle after SW_RD
    mcr_if.host LINK
);
    logic [15:0] addr_ff; // device address to touch
    logic [15:0] data_ff; // data to write
    logic [15:0] rd_ff; // last device read value
    logic [15:0] echo_ff; // last echoed start address
    logic wr_ff; // device write strobe
    logic rd_ff_s; // device read strobe
    logic rd_pend_ff; // read answer due next cycle
    logic [15:0] sw_rdata_ff;

    // software commands: GO data bit 0 writes, bit 1 reads
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            addr_ff <= 16'h0000;
            data_ff <= 16'h0000;
            wr_ff <= 1'b0;
            rd_ff_s <= 1'b0;
        end else begin
            wr_ff <= 1'b0;
            rd_ff_s <= 1'b0;
            if (SW_WR && SW_ADDR == mcr_pkg::HREG_ADDR) begin
                addr_ff <= SW_WDATA;
            end else if (SW_WR && SW_ADDR == mcr_pkg::HREG_DATA) begin
                data_ff <= SW_WDATA;
            end else if (SW_WR && SW_ADDR == mcr_pkg::HREG_GO) begin
                // flags and profile must be written before the move word
                wr_ff <= SW_WDATA[0]; // [RULE_14]
                rd_ff_s <= SW_WDATA[1] & ~SW_WDATA[0];
            end
        end
    end

    // capture device answers
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rd_pend_ff <= 1'b0;
            rd_ff <= 16'h0000;
            echo_ff <= 16'h0000;
        end else begin
            rd_pend_ff <= rd_ff_s;
            if (rd_pend_ff) begin
                rd_ff <= LINK.rdata;
            end
            if (LINK.ack) begin
                echo_ff <= LINK.ack_addr; // [RULE_17]
            end
        end
    end

    // software read port
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            sw_rdata_ff <= 16'h0000;
        end else if (SW_RD) begin
            if (SW_ADDR == mcr_pkg::HREG_ADDR) begin
                sw_rdata_ff <= addr_ff;
            end else if (SW_ADDR == mcr_pkg::HREG_DATA) begin
                sw_rdata_ff <= data_ff;
            end else if (SW_ADDR == mcr_pkg::HREG_STAT) begin
                sw_rdata_ff <= echo_ff;
            end else if (SW_ADDR == mcr_pkg::HREG_RDATA) begin
                sw_rdata_ff <= rd_ff;
            end else begin
                sw_rdata_ff <= 16'h0000;
            end
        end
    end

    assign SW_RDATA = sw_rdata_ff;
    assign LINK.wr = wr_ff;
    assign LINK.rd = rd_ff_s;
    assign LINK.addr = addr_ff;
    assign LINK.wdata = data_ff;
endmodule

/* File: testbench/mcr_chk.sv */
// concurrent checks on the host to device register link and move outputs
`timescale 1ns/10ps
module mcr_chk (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack,
    input wire logic [15:0] ack_addr,
    input wire logic MOVE_START,
    input wire logic [15:0] MOVE_ACCEL,
    input wire logic [15:0] MOVE_PRESS,
    input wire logic [1:0] MOVE_RAMP,
    input wire logic ALARM
);
    // one clock domain, so one clocking and one disable serve every property
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // writes that must launch a move: target low word, accel, press limit
    wire logic launch_wr = wr && (addr == mcr_pkg::ADDR_TGT_LO ||
        addr == mcr_pkg::ADDR_ACCEL || addr == mcr_pkg::ADDR_PRESS);
    wire logic accel_wr = wr && addr == mcr_pkg::ADDR_ACCEL; // accel write
    wire logic press_wr = wr && addr == mcr_pkg::ADDR_PRESS; // press write
    launch_start_a: assert property (launch_wr |=> MOVE_START)
        else $error("launch write gave no start pulse");
    start_cause_a: assert property (MOVE_START |-> $past(launch_wr))
        else $error("start pulse without launch write");
    accel_live_a: assert property (accel_wr |=> MOVE_ACCEL == $past(wdata))
        else $error("accel not applied at start");
    // alarm also covers zero, below the usable range
    alarm_limit_a: assert property (accel_wr |=> ALARM == ($past(wdata) >
        mcr_pkg::PRM_MAX_ACCEL || $past(wdata) == 16'h0000))
        else $error("alarm does not follow accel limit");
    press_live_a: assert property (press_wr && wdata <= mcr_pkg::PRESS_STD_MAX
        |=> MOVE_PRESS == $past(wdata)) else $error("press limit not applied");
    press_cap_a: assert property (press_wr |=> MOVE_PRESS <= mcr_pkg::PRESS_HI_MAX)
        else $error("press limit above widest range");
    flag_zero_a: assert property (rd && addr == mcr_pkg::ADDR_FLAGS
        |=> (rdata & ~mcr_pkg::FLG_MASK) == 16'h0000) else $error("spare flag bit set");
    ramp_legal_a: assert property (MOVE_RAMP != 2'h3)
        else $error("unusable ramp code reached output");
    hold_still_a: assert property (!MOVE_START |-> $stable(MOVE_ACCEL) &&
        $stable(MOVE_PRESS)) else $error("move setting changed without start");
    ack_echo_a: assert property (!wr ##1 wr ##1 !wr |-> ack &&
        ack_addr == $past(addr)) else $error("write not echoed");
    ack_cause_a: assert property (ack |-> $past(wr) && !wr)
        else $error("echo without finished write");
    // main scenarios reached
    start_c: cover property (launch_wr ##1 MOVE_START);
    alarm_c: cover property (accel_wr ##1 ALARM);
    ramp_c: cover property (MOVE_START && MOVE_RAMP == 2'h2);
endmodule

/* File: testbench/motion_command_registers_test.sv */
// self-checking bench: host end driving device end over the register link
`timescale 1ns/10ps
module motion_command_registers_test;
    logic clk_sys, nrst, sw_wr_s, sw_rd_s, high_thrust, mv_start, mv_push, mv_rev, alarm;
    logic [3:0] sw_addr; // command register index
    logic [15:0] sw_wdata, sw_rdata, mv_accel, mv_press, v, f;
    logic [31:0] cur_pos, mv_target, mv_speed;
    logic [1:0] mv_gain, mv_ramp, mv_vib;
    int n_errors = 0, n_tests = 0, n_starts = 0, s;
    logic [15:0] acc_tbl [3] = '{16'h0001, 16'h012C, 16'h012D}; // range edges
    mcr_if mcr_if_i ();
    mcr_host mcr_host_i (.CLK_SYS(clk_sys), .NRST(nrst), .SW_ADDR(sw_addr),
        .SW_WDATA(sw_wdata), .SW_WR(sw_wr_s), .SW_RD(sw_rd_s), .SW_RDATA(sw_rdata),
        .LINK(mcr_if_i));
    mcr_device mcr_device_i (.CLK_SYS(clk_sys), .NRST(nrst), .LINK(mcr_if_i),
        .CUR_POS(cur_pos), .HIGH_THRUST(high_thrust), .MOVE_START(mv_start),
        .MOVE_TARGET(mv_target), .MOVE_SPEED(mv_speed), .MOVE_ACCEL(mv_accel),
        .MOVE_PRESS(mv_press), .MOVE_PUSH(mv_push), .MOVE_REVERSE(mv_rev),
        .MOVE_GAIN(mv_gain), .MOVE_RAMP(mv_ramp), .MOVE_VIB(mv_vib), .ALARM(alarm));
    mcr_chk mcr_chk_i (.CLK_SYS(clk_sys), .NRST(nrst), .wr(mcr_if_i.wr),
        .rd(mcr_if_i.rd), .addr(mcr_if_i.addr), .wdata(mcr_if_i.wdata),
        .rdata(mcr_if_i.rdata), .ack(mcr_if_i.ack), .ack_addr(mcr_if_i.ack_addr),
        .MOVE_START(mv_start), .MOVE_ACCEL(mv_accel), .MOVE_PRESS(mv_press),
        .MOVE_RAMP(mv_ramp), .ALARM(alarm));
    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;
    // count launch pulses so silent writes can be told apart
    always @(posedge clk_sys) begin
        if (mv_start === 1'b1) n_starts++;
    end
    // verdict and end of run, also reached from any timeout
    task automatic finish_test();
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // compare with case equality so unknowns never match
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one software write; strobe stays up so back-to-back calls never glitch it
    task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr_s <= 1'b1;
        @(posedge clk_sys);
    endtask
    // one software read; data stand in the cycle after the strobe
    task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
        sw_wr_s <= 1'b0;
        sw_addr <= a;
        sw_rd_s <= 1'b1;
        @(posedge clk_sys);
        sw_rd_s <= 1'b0;
        #1 d = sw_rdata;
    endtask
    // step a cycle at a time until the sign goes high, bounded
    task automatic wait_for(ref logic sig);
        int k;
        k = 0;
        do begin
            @(posedge clk_sys);
            #1 k++;
        end while (sig !== 1'b1 && k < 20);
        if (k == 20) begin
            n_errors++;
            finish_test();
        end
    endtask
    // device register write through the host, finished when echoed
    task automatic dev_wr(input logic [15:0] a, input logic [15:0] d);
        sw_wr(mcr_pkg::HREG_ADDR, a);
        sw_wr(mcr_pkg::HREG_DATA, d);
        sw_wr(mcr_pkg::HREG_GO, 16'h0001);
        sw_wr_s <= 1'b0;
        wait_for(mcr_if_i.ack);
        @(posedge clk_sys);
        #1;
    endtask
    // device register read through the host; a margin covers the capture stage
    task automatic dev_rd(input logic [15:0] a, output logic [15:0] d);
        sw_wr(mcr_pkg::HREG_ADDR, a);
        sw_wr(mcr_pkg::HREG_GO, 16'h0002);
        sw_wr_s <= 1'b0;
        // strobe, device answer and host capture take three edges
        repeat (3) @(posedge clk_sys);
        sw_rd(mcr_pkg::HREG_RDATA, d);
    endtask
    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        {sw_wr_s, sw_rd_s, high_thrust} = 3'h0;
        sw_addr = 4'h0;
        sw_wdata = 16'h0000;
        cur_pos = 32'h0000_0000;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        // defaults out of reset come from the user parameters
        check("speed", mv_speed, mcr_pkg::PRM_DEF_SPEED);
        check("accel", mv_accel, mcr_pkg::PRM_DEF_ACCEL);
        check("press", mv_press, mcr_pkg::PRESS_FULL);
        dev_rd(mcr_pkg::ADDR_FLAGS, v);
        check("flags", v, 16'h0000);
        // target-only move: high word staged, low word launches
        s = n_starts;
        dev_wr(mcr_pkg::ADDR_TGT_HI, 16'h0000);
        check("hi starts", n_starts - s, 0);
        dev_wr(mcr_pkg::ADDR_TGT_LO, 16'h1388);
        check("lo starts", n_starts - s, 1);
        check("target", mv_target, 32'h0000_1388);
        check("speed", mv_speed, mcr_pkg::PRM_DEF_SPEED);
        sw_rd(mcr_pkg::HREG_STAT, v);
        check("echo", v, mcr_pkg::ADDR_TGT_LO);
        // accel at both range edges and one past the top
        foreach (acc_tbl[i]) begin
            s = n_starts;
            dev_wr(mcr_pkg::ADDR_ACCEL, acc_tbl[i]);
            check("accel starts", n_starts - s, 1);
            check("accel", mv_accel, acc_tbl[i]);
            check("alarm", alarm, acc_tbl[i] > 16'h012C);
        end
        dev_wr(mcr_pkg::ADDR_ACCEL, 16'h001E);
        // every code of the two-bit fields and of push and direction once, spare bits written high and dropped
        for (int r = 0; r < 4; r++) begin
            f = {2'b00, r[1:0], 4'h0, r[1:0], r[1:0], 1'b0, r[1], r[0], 1'b0};
            dev_wr(mcr_pkg::ADDR_FLAGS, f | 16'hCF01);
            dev_rd(mcr_pkg::ADDR_FLAGS, v);
            check("flag read", v, f);
            dev_wr(mcr_pkg::ADDR_PRESS, 16'h0033 + 16'(r));
            check("press", mv_press, 16'h0033 + 16'(r));
            check("push", mv_push, r[0]);
            check("reverse", mv_rev, r == 3);
            check("gain", mv_gain, r[1:0]);
            check("ramp", mv_ramp, (r == 3) ? 2'h0 : r[1:0]);
            check("vib", mv_vib, r[1:0]);
            dev_rd(mcr_pkg::ADDR_FLAGS, v);
            check("flags cleared", v, 16'h0000);
        end
        dev_wr(mcr_pkg::ADDR_PRESS, 16'h00B2);
        check("push cleared", mv_push, 1'b0);
        // press range clamp depends on the variant
        dev_wr(mcr_pkg::ADDR_PRESS, 16'h01FE);
        check("press std", mv_press, mcr_pkg::PRESS_STD_MAX);
        high_thrust <= 1'b1;
        dev_wr(mcr_pkg::ADDR_PRESS, 16'h01FE);
        check("press hi", mv_press, mcr_pkg::PRESS_HI_MAX);
        // incremental: normal adds to old target, push adds to position
        cur_pos <= 32'h0000_03E8;
        dev_wr(mcr_pkg::ADDR_FLAGS, 16'h0008);
        dev_wr(mcr_pkg::ADDR_TGT_HI, 16'h0000);
        dev_wr(mcr_pkg::ADDR_TGT_LO, 16'h0064);
        check("inc target", mv_target, 32'h0000_13EC);
        dev_wr(mcr_pkg::ADDR_FLAGS, 16'h000A);
        dev_wr(mcr_pkg::ADDR_TGT_HI, 16'h0000);
        dev_wr(mcr_pkg::ADDR_TGT_LO, 16'h0064);
        check("push inc", mv_target, 32'h0000_044C);
        finish_test();
    end
endmodule
